// ==== inc/fast_input_pkg.sv ====
package fast_input_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_FUNC_SEL = 8'h00;
  localparam logic [7:0] ADDR_FILTER_EN = 8'h04;
  localparam logic [7:0] ADDR_FILTER_MS = 8'h08;
  localparam logic [7:0] ADDR_INPUT_IMAGE = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_EFFECTIVE_FUNC = 8'h18;

  localparam int NUM_FAST = 4;
  localparam int FUNC_BITS = 4;
  localparam logic [7:0] FILTER_MS_RESET = 8'h14;
  localparam logic [7:0] FILTER_MS_MIN = 8'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLOCK_HZ = 50_000_000;
  localparam int MS_PER_SEC = 1000;
  localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_SEC;

  // Function codes of one fast input selection field.
  typedef enum logic [3:0] {
    FUNC_DIGITAL = 4'h0,
    FUNC_UP = 4'h1,
    FUNC_DOWN = 4'h2,
    FUNC_AB_UPDOWN = 4'h3,
    FUNC_AB_UPDOWN_Z = 4'h4,
    FUNC_AB_DIR = 4'h5,
    FUNC_AB_DIR_Z = 4'h6,
    FUNC_QUAD2 = 4'h7,
    FUNC_QUAD2_Z = 4'h8,
    FUNC_QUAD4 = 4'h9,
    FUNC_QUAD4_Z = 4'hA,
    FUNC_IRQ = 4'hB,
    FUNC_INPUT_B = 4'hC,
    FUNC_INDEX = 4'hD
  } func_type;

  // Inputs handed to one counter unit.
  typedef struct packed {
    func_type mode;
    logic in_a;
    logic in_b;
    logic in_z;
  } counter_feed_type;

endpackage

// ==== core/fast_input_router_filter.sv ====
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fast_input_router_filter #(
  parameter int NUM_STD = 8,
  parameter int MS_CYCLES = fast_input_pkg::CYCLES_PER_MS
) (
  input wire logic ref_clk, // System clock, 50 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic [fast_input_pkg::NUM_FAST-1:0] fast_pin, // Raw fast input pins.
  input wire logic [NUM_STD-1:0] std_pin, // Raw standard input pins.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output fast_input_pkg::counter_feed_type cnt0, // Counter 0 feed.
  output fast_input_pkg::counter_feed_type cnt1, // Counter 1 feed.
  output fast_input_pkg::counter_feed_type cnt2, // Counter 2 feed.
  output fast_input_pkg::counter_feed_type cnt3, // Counter 3 feed.
  output logic [NUM_STD+fast_input_pkg::NUM_FAST-1:0] digital_input_image, // Input image.
  output logic irq // Level interrupt, high while an unmasked event is pending.
);
  import fast_input_pkg::*;

  localparam int NUM_ALL = NUM_STD + NUM_FAST;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  // Three stages; a level counts once stages two and three agree.
  logic [NUM_ALL-1:0] sync1;
  logic [NUM_ALL-1:0] sync2;
  logic [NUM_ALL-1:0] sync3;
  logic [NUM_ALL-1:0] raw_level;
  logic [NUM_ALL-1:0] next_raw_level;

  always_comb
  begin
    next_raw_level = (sync2 & sync3) | ((sync2 ^ sync3) & raw_level);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      raw_level <= '0;
    end
    else
    begin
      sync1 <= {fast_pin, std_pin};
      sync2 <= sync1;
      sync3 <= sync2;
      raw_level <= next_raw_level;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  logic [15:0] func_sel;
  logic [NUM_ALL-1:0] filter_en;
  logic [7:0] filter_ms;
  logic [NUM_FAST-1:0] irq_status;
  logic [NUM_FAST-1:0] irq_mask;
  logic [15:0] next_func_sel;
  logic [NUM_ALL-1:0] next_filter_en;
  logic [7:0] next_filter_ms;
  logic [NUM_FAST-1:0] next_irq_status;
  logic [NUM_FAST-1:0] next_irq_mask;

  // ---------------------------------------------------------------------------
  // Millisecond tick shared by all filters
  // ---------------------------------------------------------------------------
  // One prescaler for every input keeps the filters small; the cost is up to
  // one millisecond of extra jitter on the accepted edge.
  logic [31:0] ms_div;
  logic [31:0] next_ms_div;
  logic ms_tick;

  always_comb
  begin
    ms_tick = (ms_div == 32'(MS_CYCLES - 1));
    next_ms_div = ms_tick ? 32'h0000_0000 : ms_div + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ms_div <= '0;
    else
      ms_div <= next_ms_div;
  end

  // ---------------------------------------------------------------------------
  // Debounce filters, one per input
  // ---------------------------------------------------------------------------
  logic [NUM_ALL-1:0] image_level;
  logic [NUM_ALL-1:0] next_image;

  genvar g;
  generate
    for (g = 0; g < NUM_ALL; g++)
    begin : gen_filter
      logic [8:0] hold_ms;
      logic [8:0] next_hold_ms;
      logic level;
      logic next_level;

      // Count whole milliseconds of a steady differing level; add one to cover
      // the partial first tick so the hold is never shorter than asked.
      always_comb
      begin
        next_hold_ms = hold_ms;
        next_level = level;
        if (!filter_en[g])
        begin
          next_level = raw_level[g];
          next_hold_ms = 9'h000;
        end
        else if (raw_level[g] == level)
          next_hold_ms = 9'h000;
        else if (ms_tick)
        begin
          if (hold_ms >= {1'b0, filter_ms})
          begin
            next_level = raw_level[g];
            next_hold_ms = 9'h000;
          end
          else
            next_hold_ms = hold_ms + 9'h001;
        end
      end

      always_ff @(posedge ref_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          hold_ms <= '0;
          level <= 1'b0;
        end
        else
        begin
          hold_ms <= next_hold_ms;
          level <= next_level;
        end
      end

      assign next_image[g] = filter_en[g] ? level : raw_level[g];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Function routing and partner locking
  // ---------------------------------------------------------------------------
  func_type sel0;
  func_type sel1;
  func_type sel2;
  func_type sel3;
  func_type eff1;
  func_type eff2;
  func_type eff3;
  logic c0_two;
  logic c0_idx;
  logic c2_two;
  logic [NUM_FAST-1:0] fast_lvl;
  logic [NUM_FAST-1:0] irq_sel;
  counter_feed_type next_cnt0;
  counter_feed_type next_cnt1;
  counter_feed_type next_cnt2;
  counter_feed_type next_cnt3;

  always_comb
  begin
    sel0 = func_type'(func_sel[3:0]);
    sel1 = func_type'(func_sel[7:4]);
    sel2 = func_type'(func_sel[11:8]);
    sel3 = func_type'(func_sel[15:12]);
    fast_lvl = next_image[NUM_ALL-1:NUM_STD];
    c0_two = (sel0 >= FUNC_AB_UPDOWN) && (sel0 <= FUNC_QUAD4_Z);
    // Index variants are the even codes and counter 2 pair modes the odd codes from 3 to 9.
    c0_idx = c0_two && !sel0[0];
    c2_two = (sel2 >= FUNC_AB_UPDOWN) && (sel2 <= FUNC_QUAD4) && sel2[0];
    eff1 = c0_two ? FUNC_INPUT_B : sel1;
    eff2 = c0_idx ? FUNC_INDEX : sel2;
    eff3 = (c2_two && !c0_idx) ? FUNC_INPUT_B : sel3;
    next_cnt0 = '{mode: FUNC_DIGITAL, in_a: 1'b0, in_b: 1'b0, in_z: 1'b0};
    next_cnt1 = next_cnt0;
    next_cnt2 = next_cnt0;
    next_cnt3 = next_cnt0;
    if ((sel0 >= FUNC_UP) && (sel0 <= FUNC_QUAD4_Z))
    begin
      next_cnt0.mode = sel0;
      next_cnt0.in_a = fast_lvl[0];
      next_cnt0.in_b = c0_two ? fast_lvl[1] : 1'b0;
      next_cnt0.in_z = c0_idx ? fast_lvl[2] : 1'b0;
    end
    if (eff1 == FUNC_UP || eff1 == FUNC_DOWN)
    begin
      next_cnt1.mode = eff1;
      next_cnt1.in_a = fast_lvl[1];
    end
    if (eff2 == FUNC_UP || eff2 == FUNC_DOWN || c2_two && !c0_idx)
    begin
      next_cnt2.mode = eff2;
      next_cnt2.in_a = fast_lvl[2];
      next_cnt2.in_b = (c2_two && !c0_idx) ? fast_lvl[3] : 1'b0;
    end
    if (eff3 == FUNC_UP || eff3 == FUNC_DOWN)
    begin
      next_cnt3.mode = eff3;
      next_cnt3.in_a = fast_lvl[3];
    end
    irq_sel = {eff3 == FUNC_IRQ, eff2 == FUNC_IRQ, eff1 == FUNC_IRQ, sel0 == FUNC_IRQ};
  end

  // ---------------------------------------------------------------------------
  // Rising-edge interrupts
  // ---------------------------------------------------------------------------
  logic [NUM_FAST-1:0] fast_prev;
  logic [NUM_FAST-1:0] rise_evt;

  assign rise_evt = irq_sel & fast_lvl & ~fast_prev;

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  // Address and data latch independently; the response issues once both are in.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] cur_eff;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_func_sel = func_sel;
    next_filter_en = filter_en;
    next_filter_ms = filter_ms;
    next_irq_mask = irq_mask;
    wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    cur_eff = {16'h0000, eff3, eff2, eff1, sel0};
    do_write = aw_held && w_held && !s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    next_irq_status = irq_status;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (aw_addr)
        ADDR_FUNC_SEL: next_func_sel = (func_sel & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
        ADDR_FILTER_EN: next_filter_en = (filter_en & ~wmask[NUM_ALL-1:0]) |
                                         (w_data[NUM_ALL-1:0] & wmask[NUM_ALL-1:0]);
        ADDR_FILTER_MS:
          if (w_strb[0]) // Values below the shortest time are raised to it.
            next_filter_ms = (w_data[7:0] < FILTER_MS_MIN) ? FILTER_MS_MIN : w_data[7:0];
        ADDR_IRQ_STATUS: next_irq_status = irq_status & ~(w_data[NUM_FAST-1:0] & wmask[NUM_FAST-1:0]);
        ADDR_IRQ_MASK: next_irq_mask = (irq_mask & ~wmask[NUM_FAST-1:0]) |
                                       (w_data[NUM_FAST-1:0] & wmask[NUM_FAST-1:0]);
        ADDR_INPUT_IMAGE, ADDR_EFFECTIVE_FUNC: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    next_irq_status = next_irq_status | rise_evt; // A new event wins over a clear.
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        ADDR_FUNC_SEL: next_rdata = {16'h0000, func_sel};
        ADDR_FILTER_EN: next_rdata = 32'(filter_en);
        ADDR_FILTER_MS: next_rdata = {24'h00_0000, filter_ms};
        ADDR_INPUT_IMAGE: next_rdata = 32'(digital_input_image);
        ADDR_IRQ_STATUS: next_rdata = {28'h000_0000, irq_status};
        ADDR_IRQ_MASK: next_rdata = {28'h000_0000, irq_mask};
        ADDR_EFFECTIVE_FUNC: next_rdata = cur_eff;
        default: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      func_sel <= '0;
      filter_en <= '0;
      filter_ms <= FILTER_MS_RESET;
      irq_status <= '0;
      irq_mask <= '0;
      fast_prev <= '0;
      cnt0 <= '0;
      cnt1 <= '0;
      cnt2 <= '0;
      cnt3 <= '0;
      digital_input_image <= '0;
      irq <= 1'b0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      func_sel <= next_func_sel;
      filter_en <= next_filter_en;
      filter_ms <= next_filter_ms;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      fast_prev <= fast_lvl;
      cnt0 <= next_cnt0;
      cnt1 <= next_cnt1;
      cnt2 <= next_cnt2;
      cnt3 <= next_cnt3;
      digital_input_image <= next_image;
      irq <= |(next_irq_status & next_irq_mask);
    end
  end

endmodule
`default_nettype wire

// ==== testbench/fast_input_router_filter_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module fast_input_router_filter_sva
  import fast_input_pkg::*;
#(
  parameter int NUM_STD = 8
) (
  input wire logic ref_clk, // System clock.
  input wire logic resetn, // Reset, active low.
  input wire logic [NUM_STD+fast_input_pkg::NUM_FAST-1:0] digital_input_image, // Image.
  input wire fast_input_pkg::counter_feed_type cnt0, // Counter 0 feed.
  input wire fast_input_pkg::counter_feed_type cnt1, // Counter 1 feed.
  input wire fast_input_pkg::counter_feed_type cnt2, // Counter 2 feed.
  input wire fast_input_pkg::counter_feed_type cnt3, // Counter 3 feed.
  input wire logic irq // Level interrupt.
);
  // ---------------------------------------------------------------------------
  // Routing of fast levels to the counter feeds
  // ---------------------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Feeds and image load from the same level at the same edge, so they compare directly.
  logic [3:0] fimg;
  assign fimg = digital_input_image[NUM_STD+3:NUM_STD];

  chk_c0_single: assert property (cnt0.mode inside {FUNC_UP, FUNC_DOWN}
    |-> cnt0.in_a == fimg[0]) else $error("counter 0 single feed wrong");
  chk_c0_pair: assert property (cnt0.mode inside {[FUNC_AB_UPDOWN:FUNC_QUAD4_Z]}
    |-> cnt0.in_a == fimg[0] && cnt0.in_b == fimg[1] && cnt1.mode == FUNC_DIGITAL)
    else $error("counter 0 pair feed wrong");
  chk_c0_index: assert property (cnt0.mode inside {FUNC_AB_UPDOWN_Z, FUNC_AB_DIR_Z,
    FUNC_QUAD2_Z, FUNC_QUAD4_Z} |-> cnt0.in_z == fimg[2] && cnt2.mode == FUNC_DIGITAL)
    else $error("counter 0 index feed wrong");
  chk_c1_single: assert property (cnt1.mode != FUNC_DIGITAL
    |-> cnt1.mode inside {FUNC_UP, FUNC_DOWN} && cnt1.in_a == fimg[1])
    else $error("counter 1 feed wrong");
  chk_c2_single: assert property (cnt2.mode inside {FUNC_UP, FUNC_DOWN}
    |-> cnt2.in_a == fimg[2]) else $error("counter 2 single feed wrong");
  chk_c2_pair: assert property (cnt2.mode inside {FUNC_AB_UPDOWN, FUNC_AB_DIR, FUNC_QUAD2,
    FUNC_QUAD4} |-> cnt2.in_a == fimg[2] && cnt2.in_b == fimg[3]
    && cnt3.mode == FUNC_DIGITAL) else $error("counter 2 pair feed wrong");
  chk_c3_single: assert property (cnt3.mode != FUNC_DIGITAL
    |-> cnt3.mode inside {FUNC_UP, FUNC_DOWN} && cnt3.in_a == fimg[3])
    else $error("counter 3 feed wrong");
  chk_reset_idle: assert property ($rose(resetn)
    |-> {cnt0.mode, cnt1.mode, cnt2.mode, cnt3.mode} == 16'h0000 && !irq)
    else $error("outputs not idle after reset");

  cov_quad_index: cover property (cnt0.mode == FUNC_QUAD4_Z);
  cov_c2_dir: cover property (cnt2.mode == FUNC_AB_DIR);
  cov_irq: cover property ($rose(irq));
endmodule

bind fast_input_router_filter fast_input_router_filter_sva #(.NUM_STD(NUM_STD)) u_sva (
  .ref_clk(ref_clk), .resetn(resetn), .digital_input_image(digital_input_image),
  .cnt0(cnt0), .cnt1(cnt1), .cnt2(cnt2), .cnt3(cnt3), .irq(irq));
`default_nettype wire

// ==== testbench/field_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module field_model #(
  parameter int NUM_STD = 8
) (
  input wire logic ref_clk, // Paces the field levels.
  input wire logic [3:0] want_fast, // Settled level of each fast sensor.
  input wire logic [NUM_STD-1:0] want_std, // Settled level of each standard sensor.
  input wire logic [3:0] bounce, // Fast contacts that chatter.
  output logic [3:0] fast_pin, // Fast sensor lines.
  output logic [NUM_STD-1:0] std_pin // Standard sensor lines.
);
  int ph;

  initial
  begin
    fast_pin = 4'h0;
    std_pin = '0;
    ph = 0;
  end

  // A chattering contact flips every third cycle, so no level lasts long enough to pass a filter.
  always @(posedge ref_clk)
  begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (ph == 2)
      fast_pin <= (bounce & ~fast_pin) | (~bounce & want_fast);
    else
      fast_pin <= (bounce & fast_pin) | (~bounce & want_fast);
    std_pin <= want_std;
  end
endmodule
`default_nettype wire

// ==== testbench/fast_input_router_filter_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module fast_input_router_filter_tb;
  import fast_input_pkg::*;
  localparam int NS = 8;
  localparam int LIMIT = 5000;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] want_fast = 4'h0;
  logic [3:0] bounce = 4'h0;
  logic [NS-1:0] want_std = 8'h00;
  logic [3:0] fast_pin;
  logic [NS-1:0] std_pin;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rdv;
  counter_feed_type cnt0, cnt1, cnt2, cnt3;
  logic [NS+3:0] img;
  logic seen_hi;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  // Each row: requested selections above, effective selections after locking below.
  logic [31:0] rows [12] = '{32'h0000_0000, 32'h2121_2121, 32'hB019_B0C9, 32'h17BA_1DCA,
    32'hB50B_C50B, 32'h0303_C3C3, 32'h0705_C7C5, 32'h0907_C9C7, 32'h0004_0DC4,
    32'h0006_0DC6, 32'h0008_0DC8, 32'hB2B2_B2B2};

  // A small ms tick keeps filter runs short; every filter time scales from it.
  fast_input_router_filter #(.NUM_STD(NS), .MS_CYCLES(4)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .fast_pin(fast_pin), .std_pin(std_pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cnt0(cnt0), .cnt1(cnt1), .cnt2(cnt2), .cnt3(cnt3), .digital_input_image(img), .irq(irq));

  field_model #(.NUM_STD(NS)) u_field (.ref_clk(ref_clk), .want_fast(want_fast),
    .want_std(want_std), .bounce(bounce), .fast_pin(fast_pin), .std_pin(std_pin));

  // ---------------------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ---------------------------------------------------------------------------
  always #10 ref_clk = ~ref_clk;

  // A hung handshake would stall forever, so the cycle ceiling forces a verdict.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Address and data go up together; each drops on its own acceptance.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    rsp = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    rdv = rdata;
    rsp = rresp;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask

  // Unit modes that the effective selections should switch on.
  function automatic logic [15:0] exp_modes(input logic [15:0] e);
    exp_modes[3:0] = (e[3:0] >= 4'h1 && e[3:0] <= 4'hA) ? e[3:0] : 4'h0;
    exp_modes[7:4] = (e[7:4] inside {4'h1, 4'h2}) ? e[7:4] : 4'h0;
    exp_modes[11:8] = (e[11:8] inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9}) ? e[11:8] : 4'h0;
    exp_modes[15:12] = (e[15:12] inside {4'h1, 4'h2}) ? e[15:12] : 4'h0;
  endfunction

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    cyc(20);
    resetn <= 1'b1;
    rdchk(ADDR_FUNC_SEL, 32'h0000_0000);
    rdchk(ADDR_FILTER_EN, 32'h0000_0000);
    rdchk(ADDR_FILTER_MS, 32'h0000_0014);
    rdchk(ADDR_IRQ_MASK, 32'h0000_0000);
    $display("reset values done");
    for (int i = 0; i < 12; i++)
    begin
      wr(ADDR_FUNC_SEL, {16'h0000, rows[i][31:16]});
      rdchk(ADDR_EFFECTIVE_FUNC, {16'h0000, rows[i][15:0]});
      chk({16'h0000, cnt3.mode, cnt2.mode, cnt1.mode, cnt0.mode},
        {16'h0000, exp_modes(rows[i][15:0])});
    end
    $display("selection table done");
    // Inputs owned by counters and interrupts still show up in the image.
    want_fast <= 4'hA;
    want_std <= 8'h5A;
    cyc(8);
    chk({20'h0_0000, img}, {20'h0_0000, 12'hA5A});
    rdchk(ADDR_INPUT_IMAGE, {20'h0_0000, 12'hA5A});
    $display("image done");
    wr(ADDR_FILTER_MS, 32'h0000_0001);
    rdchk(ADDR_FILTER_MS, 32'h0000_0002);
    wr(ADDR_FILTER_MS, 32'h0000_00FF);
    rdchk(ADDR_FILTER_MS, 32'h0000_00FF);
    wr(ADDR_FILTER_MS, 32'h0000_0002);
    wr(ADDR_FILTER_EN, 32'h0000_0100);
    bounce <= 4'h1;
    seen_hi = 1'b0;
    repeat (40)
    begin
      @(posedge ref_clk);
      seen_hi = seen_hi | img[NS];
    end
    chk({31'h0000_0000, seen_hi}, 32'h0000_0000);
    bounce <= 4'h0;
    cyc(12);
    want_fast <= 4'h9;
    cyc(7);
    chk({30'h0000_0000, img[NS+1:NS]}, 32'h0000_0000);
    cyc(17);
    chk({30'h0000_0000, img[NS+1:NS]}, 32'h0000_0001);
    wr(ADDR_FILTER_EN, 32'h0000_0000);
    want_fast <= 4'h0;
    cyc(7);
    chk({31'h0000_0000, img[NS]}, 32'h0000_0000);
    $display("filter done");
    wr(ADDR_FUNC_SEL, 32'h0000_B0B9);
    wr(ADDR_IRQ_STATUS, 32'h0000_000F);
    wr(ADDR_IRQ_MASK, 32'h0000_000F);
    rdchk(ADDR_IRQ_STATUS, 32'h0000_0000);
    want_fast <= 4'hA;
    cyc(10);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rdchk(ADDR_IRQ_STATUS, 32'h0000_0008);
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    cyc(3);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(ADDR_IRQ_MASK, 32'h0000_0008);
    cyc(3);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    wr(ADDR_IRQ_STATUS, 32'h0000_0008);
    cyc(3);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    want_fast <= 4'h0;
    cyc(10);
    rdchk(ADDR_IRQ_STATUS, 32'h0000_0000);
    $display("interrupt done");
    rd(8'h20);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, RESP_SLVERR});
    chk(rdv, 32'h0000_0000);
    wr(ADDR_INPUT_IMAGE, 32'h0000_0FFF);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, RESP_OKAY});
    rdchk(ADDR_INPUT_IMAGE, 32'h0000_005A);
    $display("bus errors done");
    // Counter feeds carry the live levels of the inputs that their mode claims.
    wr(ADDR_FUNC_SEL, 32'h0000_000A);
    want_fast <= 4'h7;
    cyc(8);
    chk({25'h000_0000, cnt0}, {25'h000_0000, FUNC_QUAD4_Z, 3'h7});
    wr(ADDR_FUNC_SEL, 32'h0000_0300);
    cyc(2);
    chk({25'h000_0000, cnt2}, {25'h000_0000, FUNC_AB_UPDOWN, 3'h4});
    $display("counter feeds done");
    resetn <= 1'b0;
    cyc(3);
    resetn <= 1'b1;
    rdchk(ADDR_FUNC_SEL, 32'h0000_0000);
    chk({16'h0000, cnt3.mode, cnt2.mode, cnt1.mode, cnt0.mode}, 32'h0000_0000);
    $display("second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
